/* File: rbg_pkg.sv */
package rbg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map: printed offsets are register indices, byte address is 4x
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam int BYTE_ADDR_SHIFT = 2;
    localparam int REG_IDX_W = 8;
    localparam logic [7:0] IDX_CONTROL = 8'hDC;
    localparam logic [7:0] IDX_INTERVAL_LOW = 8'hDE;
    localparam logic [7:0] IDX_INTERVAL_HIGH = 8'hE0;
    localparam logic [7:0] IDX_TEMPLATE_INDEX = 8'hE2;
    localparam logic [7:0] IDX_TEMPLATE_VALUE = 8'hE4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] REG_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Frame template and sequence identifier placement
    localparam int TEMPLATE_IDX_W = 6;
    localparam int TEMPLATE_DEPTH = 64;
    localparam logic [5:0] FRAME_LAST_POS = 6'h27;
    localparam logic [5:0] SEQ_ID_POS = 6'h1A;
    localparam logic [1:0] SEQ_ID_LAST_BYTE = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Interval timer: counts at 50 MHz, aclk runs at 10 MHz
    localparam int INTERVAL_CLOCK_HZ = 50_000_000;
    localparam int ACLK_HZ = 10_000_000;
    localparam logic [31:0] COUNTS_PER_ACLK = 32'(INTERVAL_CLOCK_HZ / ACLK_HZ);

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic gen_rst;
        logic gen_on_port_b;
        logic gen_on_port_a;
        logic timer_en;
    } rbg_ctrl_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } rbg_byte_s;

    typedef enum logic [1:0] {
        GEN_IDLE,
        GEN_ADDR,
        GEN_LOAD,
        GEN_HOLD
    } rbg_gen_e;

endpackage

/* File: rbg_template_mem.sv */
`timescale 1ns/1ps
module rbg_template_mem import rbg_pkg::*; #(
    parameter int DEPTH = TEMPLATE_DEPTH,
    parameter int IDX_W = TEMPLATE_IDX_W
) (
    // Clock
    input wire logic aclk,
    // Software write port
    input wire logic we,
    input wire logic [IDX_W-1:0] waddr,
    input wire logic [7:0] wdata,
    // Software read port
    input wire logic [IDX_W-1:0] raddr_sw,
    output logic [7:0] rdata_sw,
    // Generator read port
    input wire logic [IDX_W-1:0] raddr_gen,
    output logic [7:0] rdata_gen
);

    logic [7:0] mem [DEPTH];

    // No reset: software must load the template before use
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_sw <= mem[raddr_sw];
        rdata_gen <= mem[raddr_gen];
    end

endmodule // rbg_template_mem

/* File: rbg_beacon_gen.sv */
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rbg_beacon_gen import rbg_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Beacon byte streams toward the two ring ports
    output rbg_byte_s beacon_a,
    input wire logic tx_ready_a,
    output rbg_byte_s beacon_b,
    input wire logic tx_ready_b,
    // Per-port generation request (frame pending)
    output logic [1:0] gen_req
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rd_pend;
        logic [AXI_ADDR_W-1:0] rd_addr;
        logic rvalid;
        logic [1:0] rresp;
        logic [AXI_DATA_W-1:0] rdata;
        rbg_ctrl_s ctrl;
        logic [31:0] interval_count_value;
        logic [TEMPLATE_IDX_W-1:0] template_byte_position;
        logic timer_en_d;
        logic [31:0] remain;
        logic [31:0] seq;
        logic [1:0] pend;
        rbg_gen_e gen;
        logic port;
        logic [TEMPLATE_IDX_W-1:0] pos;
        logic [31:0] cur_seq;
        rbg_byte_s out_a;
        rbg_byte_s out_b;
    } rbg_state_s;

    rbg_state_s s;
    rbg_state_s next_s;

    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata_sw;
    logic [7:0] mem_rdata_gen;
    logic fire;
    logic timer_rise;
    logic [REG_IDX_W-1:0] wr_idx;
    logic [REG_IDX_W-1:0] rd_idx;
    logic wr_aligned;
    logic rd_aligned;
    logic [15:0] wr_merged;
    logic [15:0] wr_old;
    logic [5:0] seq_off;
    logic [1:0] seq_sel;
    logic in_seq;
    logic [7:0] gen_byte;
    logic port_ready;
    logic port_enabled;

    ////////////////////////////////////////////////////////////////////////////
    // Template storage

    rbg_template_mem #(
        .DEPTH(TEMPLATE_DEPTH),
        .IDX_W(TEMPLATE_IDX_W)
    ) u_template (
        .aclk(aclk),
        .we(mem_we),
        .waddr(s.template_byte_position),
        .wdata(mem_wdata),
        .raddr_sw(s.template_byte_position),
        .rdata_sw(mem_rdata_sw),
        .raddr_gen(s.pos),
        .rdata_gen(mem_rdata_gen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    assign wr_idx = s_axi_awaddr[BYTE_ADDR_SHIFT +: REG_IDX_W];
    assign rd_idx = s.rd_addr[BYTE_ADDR_SHIFT +: REG_IDX_W];
    // Bits below the word and above the map must be zero to hit a register
    assign wr_aligned = (s_axi_awaddr[BYTE_ADDR_SHIFT-1:0] == '0)
        && (s_axi_awaddr[AXI_ADDR_W-1:BYTE_ADDR_SHIFT+REG_IDX_W] == '0);
    assign rd_aligned = (s.rd_addr[BYTE_ADDR_SHIFT-1:0] == '0)
        && (s.rd_addr[AXI_ADDR_W-1:BYTE_ADDR_SHIFT+REG_IDX_W] == '0);

    always_comb begin
        case (wr_idx)
            IDX_CONTROL: wr_old = {12'h000, s.ctrl};
            IDX_INTERVAL_LOW: wr_old = s.interval_count_value[15:0];
            IDX_INTERVAL_HIGH: wr_old = s.interval_count_value[31:16];
            IDX_TEMPLATE_INDEX: wr_old = {10'h000, s.template_byte_position};
            default: wr_old = REG_RESET;
        endcase
    end

    assign wr_merged = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : wr_old[15:8],
                        s_axi_wstrb[0] ? s_axi_wdata[7:0] : wr_old[7:0]};

    // Sequence identifier sits big-endian over four template bytes
    assign seq_off = s.pos - SEQ_ID_POS;
    assign in_seq = (s.pos >= SEQ_ID_POS) && (seq_off[5:2] == 4'h0);
    assign seq_sel = SEQ_ID_LAST_BYTE - seq_off[1:0];
    assign gen_byte = in_seq ? s.cur_seq[{seq_sel, 3'b000} +: 8] : mem_rdata_gen;
    assign port_ready = s.port ? tx_ready_b : tx_ready_a;
    assign port_enabled = s.port ? s.ctrl.gen_on_port_b : s.ctrl.gen_on_port_a;
    assign timer_rise = s.ctrl.timer_en && !s.timer_en_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        mem_we = 1'b0;
        mem_wdata = 8'h00;
        fire = 1'b0;

        // Interval timer; a fresh enable fires at once and restarts
        next_s.timer_en_d = s.ctrl.timer_en;
        if (timer_rise) begin
            fire = 1'b1;
            next_s.remain = s.interval_count_value;
        end else if (s.ctrl.timer_en) begin
            if (s.remain <= COUNTS_PER_ACLK) begin
                fire = 1'b1;
                next_s.remain = s.interval_count_value;
            end else begin
                next_s.remain = s.remain - COUNTS_PER_ACLK;
            end
        end

        // Requests die with their enable; a new request beats a clear
        next_s.pend = s.pend & {s.ctrl.gen_on_port_b, s.ctrl.gen_on_port_a};

        // Frame serializer
        case (s.gen)
            GEN_IDLE: begin
                if (s.pend[0] && s.ctrl.gen_on_port_a) begin
                    next_s.port = 1'b0;
                    next_s.pend[0] = 1'b0;
                    next_s.gen = GEN_ADDR;
                end else if (s.pend[1] && s.ctrl.gen_on_port_b) begin
                    next_s.port = 1'b1;
                    next_s.pend[1] = 1'b0;
                    next_s.gen = GEN_ADDR;
                end
                next_s.pos = '0;
                next_s.cur_seq = s.seq;
            end
            GEN_ADDR: begin
                next_s.gen = GEN_LOAD;
            end
            GEN_LOAD: begin
                // Dropping the enable cuts the frame short before the next byte
                if (!port_enabled) begin
                    next_s.gen = GEN_IDLE;
                end else begin
                    if (s.port) begin
                        next_s.out_b = '{valid: 1'b1, data: gen_byte, last: s.pos == FRAME_LAST_POS};
                    end else begin
                        next_s.out_a = '{valid: 1'b1, data: gen_byte, last: s.pos == FRAME_LAST_POS};
                    end
                    next_s.gen = GEN_HOLD;
                end
            end
            GEN_HOLD: begin
                if (port_ready) begin
                    next_s.out_a.valid = 1'b0;
                    next_s.out_b.valid = 1'b0;
                    if (s.pos == FRAME_LAST_POS) begin
                        next_s.gen = GEN_IDLE;
                    end else begin
                        next_s.pos = s.pos + 1'b1;
                        next_s.gen = GEN_ADDR;
                    end
                end
            end
            default: begin
                next_s.gen = GEN_IDLE;
            end
        endcase

        if (fire) begin
            next_s.pend = next_s.pend | {s.ctrl.gen_on_port_b, s.ctrl.gen_on_port_a};
            next_s.seq = s.seq + 32'h0000_0001;
        end

        // Generator reset wins over everything the generator owns
        if (s.ctrl.gen_rst) begin
            fire = 1'b0;
            next_s.timer_en_d = 1'b0;
            next_s.remain = '0;
            next_s.seq = '0;
            next_s.pend = '0;
            next_s.gen = GEN_IDLE;
            next_s.pos = '0;
            next_s.cur_seq = '0;
            next_s.out_a = '0;
            next_s.out_b = '0;
        end

        // Write channel: take address and data together, answer one cycle on
        next_s.awready = !s.awready && !s.bvalid && s_axi_awvalid && s_axi_wvalid;
        next_s.wready = next_s.awready;
        if (s.awready) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            if (!wr_aligned) begin
                next_s.bresp = RESP_SLVERR;
            end else begin
                case (wr_idx)
                    IDX_CONTROL: next_s.ctrl = rbg_ctrl_s'(wr_merged[3:0]);
                    IDX_INTERVAL_LOW: next_s.interval_count_value[15:0] = wr_merged;
                    IDX_INTERVAL_HIGH: next_s.interval_count_value[31:16] = wr_merged;
                    IDX_TEMPLATE_INDEX: next_s.template_byte_position = wr_merged[5:0];
                    IDX_TEMPLATE_VALUE: begin
                        mem_we = s_axi_wstrb[0];
                        mem_wdata = s_axi_wdata[7:0];
                    end
                    default: next_s.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Read channel: one spare cycle lets the template read settle
        next_s.arready = !s.arready && !s.rd_pend && !s.rvalid && s_axi_arvalid;
        if (s.arready) begin
            next_s.rd_addr = s_axi_araddr;
            next_s.rd_pend = 1'b1;
        end
        if (s.rd_pend) begin
            next_s.rd_pend = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            next_s.rdata = '0;
            if (!rd_aligned) begin
                next_s.rresp = RESP_SLVERR;
            end else begin
                case (rd_idx)
                    IDX_CONTROL: next_s.rdata[3:0] = s.ctrl;
                    IDX_INTERVAL_LOW: next_s.rdata[15:0] = s.interval_count_value[15:0];
                    IDX_INTERVAL_HIGH: next_s.rdata[15:0] = s.interval_count_value[31:16];
                    IDX_TEMPLATE_INDEX: next_s.rdata[5:0] = s.template_byte_position;
                    IDX_TEMPLATE_VALUE: next_s.rdata[7:0] = mem_rdata_sw;
                    default: next_s.rresp = RESP_SLVERR;
                endcase
            end
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign beacon_a = s.out_a;
    assign beacon_b = s.out_b;
    assign gen_req = s.pend;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_wr_taken(logic [7:0] idx);
        s.awready && wr_aligned && (wr_idx == idx);
    endsequence

    sequence seq_frame_start(logic p);
        (s.gen == GEN_IDLE) ##1 (s.gen == GEN_ADDR && s.port == p && s.pos == '0);
    endsequence

    chk_timer_held: assert property (!s.ctrl.timer_en |-> !fire)
        else $error("beacon fired with interval timer disabled");

    chk_expiry_reload: assert property ((s.ctrl.timer_en && !s.ctrl.gen_rst && s.timer_en_d
        && s.remain <= COUNTS_PER_ACLK) |=> (s.remain == $past(s.interval_count_value))
        && (s.pend[0] || !$past(s.ctrl.gen_on_port_a)))
        else $error("timer expiry did not reload or request a beacon");

    chk_restart_fires: assert property ((timer_rise && !s.ctrl.gen_rst)
        |=> s.seq == $past(s.seq) + 32'h0000_0001)
        else $error("timer re-enable did not trigger a beacon");

    chk_port_a_gate: assert property (seq_frame_start(1'b0) |-> $past(s.ctrl.gen_on_port_a))
        else $error("frame started on port A while disabled");

    chk_port_b_gate: assert property ($rose(s.out_b.valid) |-> $past(s.ctrl.gen_on_port_b))
        else $error("port B byte produced while disabled");

    chk_seq_insert: assert property ((s.gen == GEN_HOLD && s.port == 1'b0 && s.out_a.valid
        && s.pos == SEQ_ID_POS) |-> s.out_a.data == s.cur_seq[31:24])
        else $error("sequence identifier missing from beacon");

    chk_gen_reset: assert property (s.ctrl.gen_rst |=> s.seq == '0 && s.remain == '0
        && s.pend == '0 && s.gen == GEN_IDLE && !s.out_a.valid && !s.out_b.valid)
        else $error("generator reset did not clear generation state");

    chk_count_rate: assert property ((s.ctrl.timer_en && s.timer_en_d && !s.ctrl.gen_rst
        && s.remain > COUNTS_PER_ACLK) |=> s.remain == $past(s.remain) - COUNTS_PER_ACLK)
        else $error("interval counter did not advance at the 50 MHz rate");

    chk_interval_high: assert property ((seq_wr_taken(IDX_INTERVAL_HIGH) ##0 (s_axi_wstrb[1:0] == 2'b11))
        |=> s.interval_count_value[31:16] == $past(s_axi_wdata[15:0]))
        else $error("upper interval half not stored");

    chk_index_store: assert property ((seq_wr_taken(IDX_TEMPLATE_INDEX) ##0 s_axi_wstrb[0])
        |=> s.template_byte_position == $past(s_axi_wdata[5:0]))
        else $error("template index not stored");

    chk_value_write: assert property ((seq_wr_taken(IDX_TEMPLATE_VALUE) ##0 s_axi_wstrb[0])
        |-> mem_we && mem_wdata == s_axi_wdata[7:0])
        else $error("template byte write lost");

endmodule // rbg_beacon_gen

/* File: rbg_port_sink.sv */
`timescale 1ns/1ps
module rbg_port_sink import rbg_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Byte streams from the generator
    input wire rbg_byte_s beacon_a,
    input wire rbg_byte_s beacon_b,
    output logic tx_ready_a,
    output logic tx_ready_b,
    // Pacing and observation
    input wire logic [1:0] slow,
    output logic [7:0] frame_a [40],
    output logic [7:0] frame_b [40],
    output int frames_a,
    output int frames_b,
    output int bad_len
);
    rbg_byte_s beat [2];
    logic [1:0] ready;
    logic [3:0] tick;
    logic [5:0] pos [2];
    logic [7:0] mem [2][40];
    int cnt [2];
    int bad;

    assign beat[0] = beacon_a;
    assign beat[1] = beacon_b;
    assign tx_ready_a = ready[0];
    assign tx_ready_b = ready[1];
    assign frame_a = mem[0];
    assign frame_b = mem[1];
    assign frames_a = cnt[0];
    assign frames_b = cnt[1];
    assign bad_len = bad;

    ////////////////////////////////////////////////////////////////////////////
    // A slow port takes one byte in four, so the generator must hold its byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready <= 2'b00;
            tick <= 4'h0;
            bad <= 0;
            for (int p = 0; p < 2; p++) begin
                pos[p] <= 6'h00;
                cnt[p] <= 0;
            end
        end else begin
            tick <= tick + 4'h1;
            for (int p = 0; p < 2; p++) begin
                ready[p] <= !slow[p] || (tick[1:0] == 2'h3);
                if (beat[p].valid && ready[p]) begin
                    if (pos[p] < 6'h28) begin
                        mem[p][pos[p]] <= beat[p].data;
                    end
                    pos[p] <= beat[p].last ? 6'h00 : pos[p] + 6'h01;
                    if (beat[p].last) begin
                        cnt[p] <= cnt[p] + 1;
                        if (pos[p] != FRAME_LAST_POS) begin
                            bad <= bad + 1;
                        end
                    end
                end
            end
        end
    end
endmodule // rbg_port_sink

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; $display("BAD %s expected %h seen %h", nm, ex, got); end end
module tb import rbg_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [AXI_DATA_W-1:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [AXI_DATA_W-1:0] s_axi_rdata;
    rbg_byte_s beacon_a, beacon_b;
    logic tx_ready_a, tx_ready_b;
    logic [1:0] gen_req;
    logic [1:0] slow = 2'b00;
    logic [7:0] frame_a [40];
    logic [7:0] frame_b [40];
    int frames_a, frames_b, bad_len;
    int checks = 0;
    int mismatches = 0;
    int cyc = 0;
    int t0, t1, t2;

    rbg_beacon_gen rbg_beacon_gen_inst (.*);
    rbg_port_sink rbg_port_sink_inst (.*);

    always #50 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks; both write channels offered together, released once taken
    task automatic axi_wr(input logic [7:0] idx, input logic [15:0] val, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {16'h0000, val};
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] idx, input logic [15:0] ev, input logic [1:0] er, input string nm);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        `CHK(nm, {16'h0000, ev}, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic [7:0] tmpl(input int i);
        return 8'(i * 7 + 17);
    endfunction

    // Sequence id replaces bytes 26..29, most significant byte first
    task automatic check_frame(input logic [7:0] f [40], input logic [31:0] seq, input string nm);
        logic [7:0] eb;
        for (int i = 0; i < 40; i++) begin
            eb = (i >= 26 && i <= 29) ? seq[8 * (29 - i) +: 8] : tmpl(i);
            `CHK(nm, eb, f[i])
        end
    endtask

    task automatic wait_frames(input int na, input int nb);
        while (frames_a != na || frames_b != nb) @(posedge aclk);
    endtask

    task stop_test;
        $display("Counts: checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(IDX_CONTROL, 16'h0000, RESP_OKAY, "control");
        axi_rd(IDX_INTERVAL_LOW, 16'h0000, RESP_OKAY, "interval_low");
        axi_rd(IDX_INTERVAL_HIGH, 16'h0000, RESP_OKAY, "interval_high");
        axi_rd(IDX_TEMPLATE_INDEX, 16'h0000, RESP_OKAY, "index");
        axi_wr(8'hE6, 16'h1234, RESP_SLVERR);
        axi_rd(8'hE6, 16'h0000, RESP_SLVERR, "unmapped");
        axi_wr(IDX_INTERVAL_LOW, 16'h4E20, RESP_OKAY);
        axi_wr(IDX_INTERVAL_HIGH, 16'hABCD, RESP_OKAY);
        axi_rd(IDX_INTERVAL_LOW, 16'h4E20, RESP_OKAY, "interval_low");
        axi_rd(IDX_INTERVAL_HIGH, 16'hABCD, RESP_OKAY, "interval_high");
        axi_wr(IDX_INTERVAL_HIGH, 16'h0000, RESP_OKAY);
        axi_wr(IDX_TEMPLATE_INDEX, 16'hFFFF, RESP_OKAY);
        axi_rd(IDX_TEMPLATE_INDEX, 16'h003F, RESP_OKAY, "index_width");
        for (int i = 0; i < 40; i++) begin
            axi_wr(IDX_TEMPLATE_INDEX, 16'(i), RESP_OKAY);
            axi_wr(IDX_TEMPLATE_VALUE, {8'h00, tmpl(i)}, RESP_OKAY);
        end
        axi_wr(IDX_TEMPLATE_INDEX, 16'h0005, RESP_OKAY);
        axi_rd(IDX_TEMPLATE_VALUE, {8'h00, tmpl(5)}, RESP_OKAY, "value");
        // Ports enabled but the timer stopped: nothing may go out
        axi_wr(IDX_CONTROL, 16'h0006, RESP_OKAY);
        repeat (100) @(posedge aclk);
        `CHK("gen_req_idle", 2'b00, gen_req)
        `CHK("frames_idle", 0, frames_a + frames_b)
        // Port A only; second beacon one full interval after the first
        axi_wr(IDX_CONTROL, 16'h0003, RESP_OKAY);
        wait_frames(1, 0);
        t1 = cyc;
        check_frame(frame_a, 32'h0000_0001, "frame_a_first");
        wait_frames(2, 0);
        t2 = cyc;
        `CHK("period", 1'b1, (t2 - t1 >= 3999 && t2 - t1 <= 4001))
        check_frame(frame_a, 32'h0000_0002, "frame_a_second");
        `CHK("frames_b_off", 0, frames_b)
        // Toggling the timer gives an immediate beacon; port B paced slowly
        slow <= 2'b10;
        axi_wr(IDX_CONTROL, 16'h0006, RESP_OKAY);
        axi_wr(IDX_CONTROL, 16'h0007, RESP_OKAY);
        t0 = cyc;
        // Port B request must stay pending while port A sends its frame
        repeat (20) @(posedge aclk);
        `CHK("gen_req_b_pending", 2'b10, gen_req)
        wait_frames(3, 1);
        `CHK("immediate", 1'b1, (cyc - t0 < 1000))
        check_frame(frame_a, 32'h0000_0003, "frame_a_both");
        check_frame(frame_b, 32'h0000_0003, "frame_b_both");
        // Generator reset stops everything and restarts the sequence id
        axi_wr(IDX_CONTROL, 16'h000F, RESP_OKAY);
        repeat (5000) @(posedge aclk);
        `CHK("frames_in_reset", 4, frames_a + frames_b)
        `CHK("gen_req_reset", 2'b00, gen_req)
        `CHK("valid_reset", 1'b0, beacon_a.valid | beacon_b.valid)
        axi_wr(IDX_CONTROL, 16'h0007, RESP_OKAY);
        wait_frames(4, 2);
        check_frame(frame_a, 32'h0000_0001, "frame_a_restart");
        check_frame(frame_b, 32'h0000_0001, "frame_b_restart");
        // Timer running with both ports off: expiries produce nothing
        axi_wr(IDX_CONTROL, 16'h0001, RESP_OKAY);
        repeat (5000) @(posedge aclk);
        `CHK("frames_a_off", 4, frames_a)
        `CHK("frames_b_off", 2, frames_b)
        `CHK("gen_req_off", 2'b00, gen_req)
        `CHK("frame_length", 0, bad_len)
        stop_test;
    end

    // Whole run needs about 15000 cycles
    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        $display("BAD watchdog expected finish seen hang");
        stop_test;
    end
endmodule // tb
